// *** hdl/bst_defs.vh ***
`ifndef BST_DEFS_VH
`define BST_DEFS_VH

// ****************************************
// Instruction register
// ****************************************
`define BST_IR_W 3
`define BST_OP_EXTERNAL 3'h0
`define BST_OP_IDENT 3'h1
`define BST_OP_SAMPLE 3'h2
`define BST_OP_FLOAT 3'h3
`define BST_OP_HOLD 3'h4
`define BST_OP_SPARE_A 3'h5
`define BST_OP_SPARE_B 3'h6
`define BST_OP_PASS 3'h7
// Fixed pattern loaded on capture of the instruction path
`define BST_IR_CAPTURE 3'h1

// ****************************************
// Identification word layout
// ****************************************
`define BST_ID_W 32
`define BST_ID_VER_W 4
`define BST_ID_PART_W 16
`define BST_ID_MFR_W 11
`define BST_ID_LSB 1'h1

// ****************************************
// Data path selection codes
// ****************************************
`define BST_SEL_PASS 2'h0
`define BST_SEL_IDENT 2'h1
`define BST_SEL_BOUND 2'h2

// ****************************************
// Timing
// ****************************************
// Flip-flops in each pin synchroniser
`define BST_SYNC_STAGES 2

`endif

// *** hdl/bst_sync.v ***
`timescale 1ns/1ps
`default_nettype none
`include "bst_defs.vh"

// ****************************************
// Two-stage synchroniser for pin levels
// ****************************************
module bst_sync #(
   parameter W = 1
) (
   input wire i_clk,
   input wire i_nrst,
   input wire [W-1:0] i_d,
   output wire [W-1:0] o_q
);

   reg [W-1:0] meta_q; // First stage, read only by the second
   reg [W-1:0] sync_q; // Second stage, safe for logic

   // Both stages reset to zero; no port value enters the reset branch
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= i_d;
         sync_q <= meta_q;
      end
   end

   assign o_q = sync_q;

endmodule
`default_nettype wire

// *** hdl/bst_bsr.v ***
`timescale 1ns/1ps
`default_nettype none
`include "bst_defs.vh"

// ****************************************
// Boundary register: capture, shift, update
// ****************************************
module bst_bsr #(
   parameter W = 8
) (
   input wire i_clk,
   input wire i_nrst,
   input wire i_capture,
   input wire i_shift,
   input wire i_update,
   input wire i_tdi,
   input wire [W-1:0] i_par,
   output wire o_so,
   output wire [W-1:0] o_upd
);

   reg [W-1:0] sh_q;  // Shift stage, seen on the scan path
   reg [W-1:0] upd_q; // Update stage, drives pins in test modes

   // Shift stage moves toward bit 0; new bit enters at the top
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sh_q <= {W{1'b0}};
      end else if (i_capture) begin
         sh_q <= i_par;
      end else if (i_shift) begin
         sh_q <= {i_tdi, sh_q[W-1:1]};
      end
   end

   // Update stage holds still while shifting so pins do not ripple
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         upd_q <= {W{1'b0}};
      end else if (i_update) begin
         upd_q <= sh_q;
      end
   end

   assign o_so = sh_q[0];
   assign o_upd = upd_q;

endmodule
`default_nettype wire

// *** hdl/bst_tap.v ***
`timescale 1ns/1ps
`default_nettype none
`include "bst_defs.vh"

// Operation
// - Five pins: reset, clock, mode, data in/out
// - Code 000 puts boundary register on path
// - External test: cells drive outputs, capture inputs
// - Code 001 puts identification register on path
// - Identification access leaves function undisturbed
// - ID: version, part, maker, LSB one
// - Code 010 samples functional values, normal operation
// - Sample also preloads cells before test modes
// - Code 011 floats outputs, bypass on path
// - Code 100 holds outputs from cells, bypass
// - Code 111 single bypass flop, normal operation
module bst_tap #(
   parameter N_IN = 4,
   parameter N_OUT = 4,
   parameter [`BST_ID_VER_W-1:0] ID_VERSION = 4'h1,  // Arbitrary value
   parameter [`BST_ID_PART_W-1:0] ID_PART = 16'h5A5A, // Arbitrary value
   parameter [`BST_ID_MFR_W-1:0] ID_MFR = 11'h2A3    // Arbitrary value
) (
   input wire i_clk,
   input wire i_nrst,
   input wire i_test_rst_n,
   input wire i_test_clock_in,
   input wire i_tms,
   input wire i_tdi,
   output wire o_tdo,
   output wire o_tdo_oe,
   input wire [N_OUT-1:0] i_core_out,
   input wire [N_OUT-1:0] i_core_oe,
   input wire [N_IN-1:0] i_pin_in,
   output wire [N_OUT-1:0] o_pin_out,
   output wire [N_OUT-1:0] o_pin_oe,
   output wire [N_IN-1:0] o_core_in
);

   // ****************************************
   // Controller state codes
   // ****************************************
   localparam [3:0] ST_RESET = 4'h0;
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_SEL_DR = 4'h2;
   localparam [3:0] ST_CAP_DR = 4'h3;
   localparam [3:0] ST_SHIFT_DR = 4'h4;
   localparam [3:0] ST_EXIT1_DR = 4'h5;
   localparam [3:0] ST_PAUSE_DR = 4'h6;
   localparam [3:0] ST_EXIT2_DR = 4'h7;
   localparam [3:0] ST_UPD_DR = 4'h8;
   localparam [3:0] ST_SEL_IR = 4'h9;
   localparam [3:0] ST_CAP_IR = 4'hA;
   localparam [3:0] ST_SHIFT_IR = 4'hB;
   localparam [3:0] ST_EXIT1_IR = 4'hC;
   localparam [3:0] ST_PAUSE_IR = 4'hD;
   localparam [3:0] ST_EXIT2_IR = 4'hE;
   localparam [3:0] ST_UPD_IR = 4'hF;

   localparam NB = N_IN + N_OUT; // Boundary register length
   localparam NS = N_IN + 4;     // Synchronised pin count

   // ****************************************
   // Decode helpers
   // ****************************************
   // Map instruction to the data path it selects
   function [1:0] dr_sel;
      input [`BST_IR_W-1:0] op;
      begin
         if (op == `BST_OP_EXTERNAL || op == `BST_OP_SAMPLE) begin
            dr_sel = `BST_SEL_BOUND;
         end else if (op == `BST_OP_IDENT) begin
            dr_sel = `BST_SEL_IDENT;
         end else begin
            dr_sel = `BST_SEL_PASS;
         end
      end
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   wire [NS-1:0] sync_out; // All pin levels after two flops
   wire trst_n_s;          // Test reset, synchronised
   wire tck_s;             // Test clock, synchronised
   wire tms_s;             // Mode select, synchronised
   wire tdi_s;             // Serial input, synchronised
   wire [N_IN-1:0] pin_in_s; // Functional inputs, synchronised

   // Test clock is sampled, not used as a clock; it must be slow
   bst_sync #(
      .W(NS)
   ) u_sync (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_d({i_pin_in, i_test_rst_n, i_test_clock_in, i_tms, i_tdi}),
      .o_q(sync_out)
   );

   assign pin_in_s = sync_out[NS-1:4];
   assign trst_n_s = sync_out[3];
   assign tck_s = sync_out[2];
   assign tms_s = sync_out[1];
   assign tdi_s = sync_out[0];

   // ****************************************
   // Test clock edge detection
   // ****************************************
   reg tck_q; // Previous synchronised test clock
   wire rise; // One-cycle pulse on a rising test clock edge
   wire fall; // One-cycle pulse on a falling test clock edge

   // Delay the already-synchronised level by one cycle
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tck_q <= 1'b0;
      end else begin
         tck_q <= tck_s;
      end
   end

   // Mode and data travel through equal delay, so they stay aligned
   assign rise = tck_s & ~tck_q;
   assign fall = ~tck_s & tck_q;

   // ****************************************
   // Controller state machine
   // ****************************************
   reg [3:0] state_q; // Present controller state
   reg [3:0] state_d; // Next state on a rising edge

   // Standard next-state table steered by mode select
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RESET: state_d = tms_s ? ST_RESET : ST_IDLE;
         ST_IDLE: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: state_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: state_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_SHIFT_DR: state_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_EXIT1_DR: state_d = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
         ST_PAUSE_DR: state_d = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
         ST_EXIT2_DR: state_d = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
         ST_UPD_DR: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: state_d = tms_s ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: state_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_SHIFT_IR: state_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_EXIT1_IR: state_d = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
         ST_PAUSE_IR: state_d = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
         ST_EXIT2_IR: state_d = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
         // Update-IR, the only code left
         default: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
      endcase
   end

   // Test reset pin forces the reset state once synchronised, without waiting for a test clock edge
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= ST_RESET;
      end else if (!trst_n_s) begin
         state_q <= ST_RESET;
      end else if (rise) begin
         state_q <= state_d;
      end
   end

   // ****************************************
   // Instruction register
   // ****************************************
   reg [`BST_IR_W-1:0] ir_sh_q; // Instruction shift stage
   reg [`BST_IR_W-1:0] ir_q;    // Active instruction

   // Shift stage: capture fixed pattern, then shift toward bit 0
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ir_sh_q <= `BST_IR_CAPTURE;
      end else if (rise && state_q == ST_CAP_IR) begin
         ir_sh_q <= `BST_IR_CAPTURE;
      end else if (rise && state_q == ST_SHIFT_IR) begin
         ir_sh_q <= {tdi_s, ir_sh_q[`BST_IR_W-1:1]};
      end
   end

   // Active instruction changes only on the falling edge in update, or to identification in the reset state
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ir_q <= `BST_OP_IDENT;
      end else if (state_q == ST_RESET) begin
         ir_q <= `BST_OP_IDENT;
      end else if (fall && state_q == ST_UPD_IR) begin
         ir_q <= ir_sh_q;
      end
   end

   wire [1:0] sel = dr_sel(ir_q); // Data path chosen by instruction

   // ****************************************
   // Bypass and identification registers
   // ****************************************
   reg pass_q;                 // One-bit bypass stage
   reg [`BST_ID_W-1:0] id_q;   // Identification shift stage
   wire [`BST_ID_W-1:0] id_word; // Fixed identification word

   assign id_word = {ID_VERSION, ID_PART, ID_MFR, `BST_ID_LSB};

   // Bypass captures zero and passes one bit per clock
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pass_q <= 1'b0;
      end else if (rise && sel == `BST_SEL_PASS) begin
         if (state_q == ST_CAP_DR) begin
            pass_q <= 1'b0;
         end else if (state_q == ST_SHIFT_DR) begin
            pass_q <= tdi_s;
         end
      end
   end

   // Identification path touches nothing on the functional side
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         id_q <= {`BST_ID_W{1'b0}};
      end else if (rise && sel == `BST_SEL_IDENT) begin
         if (state_q == ST_CAP_DR) begin
            id_q <= id_word;
         end else if (state_q == ST_SHIFT_DR) begin
            id_q <= {tdi_s, id_q[`BST_ID_W-1:1]};
         end
      end
   end

   // ****************************************
   // Boundary register
   // ****************************************
   wire bsr_sel = (sel == `BST_SEL_BOUND);
   wire bsr_so;           // Boundary serial output
   wire [NB-1:0] bsr_upd; // Boundary update stage
   reg [N_OUT-1:0] pin_out_q; // Registered output pin values
   reg [N_OUT-1:0] pin_oe_q;  // Registered output pin enables
   reg [N_IN-1:0] core_in_q;  // Registered inputs toward the core

   // Inputs sit at the low end, outputs above them
   bst_bsr #(
      .W(NB)
   ) u_bsr (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_capture(rise && bsr_sel && state_q == ST_CAP_DR),
      .i_shift(rise && bsr_sel && state_q == ST_SHIFT_DR),
      .i_update(fall && bsr_sel && state_q == ST_UPD_DR),
      .i_tdi(tdi_s),
      .i_par({pin_out_q, pin_in_s}),
      .o_so(bsr_so),
      .o_upd(bsr_upd)
   );

   // ****************************************
   // Pin multiplexing
   // ****************************************
   wire drive_bsr = (ir_q == `BST_OP_EXTERNAL) || (ir_q == `BST_OP_HOLD);
   wire float_all = (ir_q == `BST_OP_FLOAT);

   // Registered so pins never glitch between sources
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pin_out_q <= {N_OUT{1'b0}};
         pin_oe_q <= {N_OUT{1'b0}};
         core_in_q <= {N_IN{1'b0}};
      end else begin
         core_in_q <= pin_in_s; // Core always sees the real pins
         if (float_all) begin
            pin_out_q <= i_core_out;
            pin_oe_q <= {N_OUT{1'b0}};
         end else if (drive_bsr) begin
            pin_out_q <= bsr_upd[NB-1:N_IN];
            pin_oe_q <= {N_OUT{1'b1}};
         end else begin
            pin_out_q <= i_core_out;
            pin_oe_q <= i_core_oe;
         end
      end
   end

   assign o_pin_out = pin_out_q;
   assign o_pin_oe = pin_oe_q;
   assign o_core_in = core_in_q;

   // ****************************************
   // Serial output
   // ****************************************
   reg tdo_q;    // Serial output bit
   reg tdo_oe_q; // Driven only while shifting
   reg so_mux;   // Selected serial source

   // Instruction path wins in its own shift state
   always @* begin
      so_mux = pass_q;
      if (state_q == ST_SHIFT_IR) begin
         so_mux = ir_sh_q[0];
      end else if (sel == `BST_SEL_IDENT) begin
         so_mux = id_q[0];
      end else if (sel == `BST_SEL_BOUND) begin
         so_mux = bsr_so;
      end
   end

   // Output moves on the falling edge, a half clock after shifting
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (fall) begin
         tdo_q <= so_mux;
         tdo_oe_q <= (state_q == ST_SHIFT_IR) || (state_q == ST_SHIFT_DR);
      end
   end

   assign o_tdo = tdo_q;
   assign o_tdo_oe = tdo_oe_q;

endmodule
`default_nettype wire

// *** testbench/bst_tap_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Port-level checker
// ****
module bst_tap_chk #(
   parameter N_IN = 4,
   parameter N_OUT = 4
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_test_rst_n,
   input wire logic i_test_clock_in,
   input wire logic i_tms,
   input wire logic i_tdi,
   input wire logic o_tdo,
   input wire logic o_tdo_oe,
   input wire logic [N_OUT-1:0] i_core_out,
   input wire logic [N_OUT-1:0] i_core_oe,
   input wire logic [N_IN-1:0] i_pin_in,
   input wire logic [N_OUT-1:0] o_pin_out,
   input wire logic [N_OUT-1:0] o_pin_oe,
   input wire logic [N_IN-1:0] o_core_in
);
   // Cycles since reset release; masks pipeline fill
   logic [2:0] age_q;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         age_q <= 3'h0;
      end else if (age_q != 3'h7) begin
         age_q <= age_q + 3'h1;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // Test reset held past its synchroniser delay
   sequence s_trst_held;
      !i_test_rst_n [*7];
   endsequence
   // Driven for one whole test clock period
   sequence s_oe_held;
      o_tdo_oe [*8];
   endsequence
   AST_CORE_IN: assert property (age_q > 3'h3 |-> o_core_in == $past(i_pin_in, 3))
      else $error("core input not three cycles behind pins");
   AST_OE_SHAPE: assert property (age_q > 3'h1 |-> o_pin_oe == {N_OUT{1'b1}}
      || o_pin_oe == '0 || o_pin_oe == $past(i_core_oe))
      else $error("pin enables neither forced nor functional");
   AST_PIN_FOLLOW: assert property (age_q > 3'h1 && o_pin_oe == $past(i_core_oe)
      && o_pin_oe != {N_OUT{1'b1}} && o_pin_oe != '0 |-> o_pin_out == $past(i_core_out))
      else $error("functional pins not following core");
   AST_TRST_FUNC: assert property (s_trst_held |-> o_pin_oe == $past(i_core_oe)
      && o_pin_out == $past(i_core_out))
      else $error("test reset did not restore functional pins");
   AST_TRST_OE: assert property (s_trst_held |-> !o_tdo_oe)
      else $error("data out driven during test reset");
   AST_TDO_EDGE: assert property ($changed(o_tdo) || $changed(o_tdo_oe)
      |-> !$past(i_test_clock_in, 2))
      else $error("data out moved away from a falling test clock");
   AST_OE_HOLD: assert property ($rose(o_tdo_oe) |-> s_oe_held)
      else $error("data out enable shorter than one test clock");
   // Output stage reloads on every falling edge, shifting or not, so it
   // may move only when the synchronised clock has just fallen
   AST_TDO_QUIET: assert property (age_q > 3'h3
      && $past(i_test_clock_in, 3) == $past(i_test_clock_in, 4)
      |-> $stable(o_tdo) && $stable(o_tdo_oe))
      else $error("data out moved without a falling test clock");
endmodule

bind bst_tap bst_tap_chk #(.N_IN(N_IN), .N_OUT(N_OUT)) chk_u (.i_clk, .i_nrst,
   .i_test_rst_n, .i_test_clock_in, .i_tms, .i_tdi, .o_tdo, .o_tdo_oe, .i_core_out,
   .i_core_oe, .i_pin_in, .o_pin_out, .o_pin_oe, .o_core_in);
`default_nettype wire

// *** testbench/bst_tester.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Scan tester model
// ****
module bst_tester (
   input wire logic i_clk,
   input wire logic i_tdo,
   output logic o_test_rst_n,
   output logic o_test_clock_in,
   output logic o_tms,
   output logic o_tdi
);
   // Idle levels: clock pulled down, the rest pulled up
   initial begin
      o_test_rst_n = 1'b1;
      o_test_clock_in = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end
   // One 800 ns test clock; caller starts just after a system edge
   task automatic step(input logic m, input logic d, output logic q);
      o_tms = m;
      o_tdi = d;
      repeat (4) @(posedge i_clk);
      #1;
      q = i_tdo; // Settled well before the rise
      o_test_clock_in = 1'b1;
      repeat (4) @(posedge i_clk);
      #1;
      o_test_clock_in = 1'b0;
   endtask
   // Five mode-high clocks, then idle
   task automatic to_idle();
      logic b;
      @(posedge i_clk);
      #1;
      repeat (5) step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
      o_tms = 1'b1;
   endtask
   // Test reset pulse, long enough for the synchroniser
   task automatic trst_pulse();
      @(posedge i_clk);
      #1;
      o_test_rst_n = 1'b0;
      repeat (10) @(posedge i_clk);
      #1;
      o_test_rst_n = 1'b1;
   endtask
   // Idle to idle scan of n bits, LSB first
   task automatic scan(input logic ir, input int n, input logic [31:0] d,
                       output logic [31:0] q);
      logic b;
      @(posedge i_clk);
      #1;
      step(1'b1, 1'b1, b);
      if (ir) step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b); // Capture
      step(1'b0, 1'b1, b); // Into shift
      q = 32'h0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1 || (!ir && i == 7), d[i], b);
         q[i] = b;
         // Data scans rest in pause once, then resume shifting
         if (!ir && i == 7) begin
            step(1'b0, 1'b1, b);
            step(1'b1, 1'b1, b);
            step(1'b0, 1'b1, b);
         end
      end
      step(1'b1, 1'b1, b); // Update on the fall
      step(1'b0, 1'b1, b);
      o_tms = 1'b1; // Released to pull-up
      o_tdi = 1'b1;
   endtask
endmodule
`default_nettype wire

// *** testbench/bst_tap_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Testbench
// ****
module bst_tap_test;
   // Arbitrary identification fields
   localparam logic [31:0] ID_WORD = {4'h3, 16'hC0DE, 11'h155, 1'b1};
   logic i_clk;
   logic i_nrst;
   logic [3:0] core_out, core_oe, pin_in;
   wire logic trst_n, tck, tms, tdi, tdo, tdo_oe;
   wire logic [3:0] pin_out, pin_oe, core_in;
   int fail_count = 0;
   int check_count = 0;
   bst_tap #(.ID_VERSION(4'h3), .ID_PART(16'hC0DE), .ID_MFR(11'h155)) dut_u (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_test_rst_n(trst_n), .i_test_clock_in(tck),
      .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_core_out(core_out),
      .i_core_oe(core_oe), .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
      .o_core_in(core_in));
   bst_tester tester_u (.i_clk(i_clk), .i_tdo(tdo), .o_test_rst_n(trst_n),
      .o_test_clock_in(tck), .o_tms(tms), .o_tdi(tdi));
   // 10 MHz system clock
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task automatic summarize();
      if (fail_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Pin state expected from the active instruction
   task automatic pins(input int code, input logic [7:0] upd);
      repeat (4) @(posedge i_clk);
      #1;
      check(core_in, pin_in);
      check(tdo_oe, 1'b0);
      if (code == 3) check(pin_oe, 4'h0);
      else if (code == 0 || code == 4) check({pin_oe, pin_out}, {4'hF, upd[7:4]});
      else check({pin_oe, pin_out}, {core_oe, core_out});
   endtask
   // Hang guard, well beyond the expected run
   initial begin
      #3ms;
      fail_count++;
      summarize();
   end
   // ****
   // Main sequence
   // ****
   initial begin
      static int codes[9] = '{2, 0, 1, 2, 3, 4, 5, 6, 7};
      logic [31:0] q, d, e, cap;
      logic [7:0] upd;
      int len;
      i_nrst = 1'b0;
      core_out = 4'h0;
      core_oe = 4'h0;
      pin_in = 4'h0;
      q = $urandom(32'hB5D0C335);
      repeat (8) @(posedge i_clk);
      #1;
      i_nrst = 1'b1;
      tester_u.trst_pulse();
      tester_u.to_idle();
      tester_u.scan(1'b0, 32, 32'h0, q);
      check(q, ID_WORD);
      upd = 8'h00;
      // Every code, preload first; model shifts ahead of the data in
      foreach (codes[k]) begin
         core_out = $urandom;
         core_oe = $urandom;
         pin_in = $urandom;
         tester_u.scan(1'b1, 3, {29'h0, codes[k][2:0]}, q);
         check(q[2:0], 3'h1);
         pins(codes[k], upd);
         d = $urandom;
         tester_u.scan(1'b0, 32, d, q);
         len = (codes[k] == 1) ? 32 : (codes[k] == 0 || codes[k] == 2) ? 8 : 1;
         cap = (codes[k] == 1) ? ID_WORD : (codes[k] == 0) ? {upd[7:4], pin_in} :
               (codes[k] == 2) ? {core_out, pin_in} : 32'h0;
         e = 32'((64'(cap) & ((64'h1 << len) - 64'h1)) | (64'(d) << len));
         check(q, e);
         if (codes[k] == 0 || codes[k] == 2) upd = d[31:24];
         pins(codes[k], upd);
      end
      // Mode-high reset out of float
      tester_u.scan(1'b1, 3, 32'h3, q);
      tester_u.to_idle();
      pins(1, upd);
      // Test reset pin out of clamp
      tester_u.scan(1'b1, 3, 32'h4, q);
      tester_u.trst_pulse();
      pins(1, upd);
      tester_u.to_idle();
      tester_u.scan(1'b0, 32, 32'h0, q);
      check(q, ID_WORD);
      summarize();
   end
endmodule
`default_nettype wire
